// ### hdl/dur_pkg.sv
// ----------------------------------------------------------------------
// Overview of operation
// R01: divisor bytes load 0x00 high, 0x01 low on power-up only, not pin reset
// R02: four pause/resume characters per channel, read/write, reset to zero
// R03: interrupt status register reads 0x01 after reset, nothing pending
// R04: line status register reads 0x60 after reset
// R05: modem status low nibble cleared on reset; high nibble is inverted pins
// R06: scratch register is all ones after reset
// R07: reset clears interrupt enable, fifo/line/modem ctrl, enhanced, fraction
// R08: holding registers are left undefined by reset
// R09: reset drives tx, out2, rts, dtr, receive-ready high; transmit-ready low
// R10: during reset the interrupt pin floats in mode 16, driven high in mode 68
// R11: low-power sleep isolates bus and serial inputs, modem inputs stay live
// ----------------------------------------------------------------------
package dur_pkg;

    // ------------------------------------------------------------------
    // register word indices inside one channel
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_HOLD = 4'h0, REG_IER = 4'h1;
    localparam logic [3:0] REG_FCR_ISR = 4'h2, REG_LCR = 4'h3;
    localparam logic [3:0] REG_MCR = 4'h4, REG_LSR = 4'h5;
    localparam logic [3:0] REG_MSR = 4'h6, REG_SPR = 4'h7;
    localparam logic [3:0] REG_DIV_LO = 4'h8, REG_DIV_HI = 4'h9;
    localparam logic [3:0] REG_FRAC = 4'ha, REG_EFR = 4'hb;
    localparam logic [3:0] REG_RES1 = 4'hc, REG_RES2 = 4'hd;
    localparam logic [3:0] REG_PAU1 = 4'he, REG_PAU2 = 4'hf;
    localparam int ADDR_CH_BIT = 4;
    localparam int ADDR_HOLE_BIT = 5;

    // ------------------------------------------------------------------
    // reset and power-up values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ISR = 8'h01;
    localparam logic [7:0] RST_LSR = 8'h60;
    localparam logic [7:0] RST_SPR = 8'hff;
    localparam logic [7:0] PWR_DIV_HI = 8'h00;
    localparam logic [7:0] PWR_DIV_LO = 8'h01;

    // ------------------------------------------------------------------
    // field positions and enhanced-bit masks
    // ------------------------------------------------------------------
    localparam int EFR_ENH_BIT = 4;
    localparam int IER_SLEEP_BIT = 4;
    localparam int LCR_BRK_BIT = 6;
    localparam int MCR_DTR_BIT = 0, MCR_RTS_BIT = 1, MCR_OUT1_BIT = 2;
    localparam int MCR_OUT2_BIT = 3, MCR_LOOP_BIT = 4;
    localparam int LSR_RECEIVE_READY_N_BIT = 0, LSR_THRE_BIT = 5;
    localparam logic [7:0] ENH_IER = 8'hf0;
    localparam logic [7:0] ENH_FCR = 8'h30;
    localparam logic [7:0] ENH_MCR = 8'he0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] interrupt_enable_reg, fifo_control_reg, interrupt_status_reg, line_control_reg, modem_control_reg, line_status_reg, scratch_reg, enhanced_feature_reg, fractional_divisor;
        logic [7:0] res1, res2, pau1, pau2;
        logic [3:0] msr_d;
    } dur_chan_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } dur_div_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic be0;
        logic [5:0] addr;
        logic [7:0] wdata;
    } dur_req_t;

    typedef struct packed {
        logic cd_n, ri_n, dsr_n, cts_n;
    } dur_modem_t;

    typedef struct packed {
        logic tx, op2_n, rts_n, dtr_n, receive_ready_n_n, transmit_ready_n_n, irq, irq_oe;
    } dur_pins_t;

endpackage

// ### hdl/dur_sync3.sv
`timescale 1ns/10ps
module dur_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

    // ------------------------------------------------------------------
    // three stages; a bit changes once stages two and three agree
    // ------------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
        // in reset follow the pins: straps must act while reset is held
        if (sys_rst) begin
            q_nxt = s3_r;
        end
    end

    always_ff @(posedge clk) begin
        s1_r <= d;
        s2_r <= s1_r;
        s3_r <= s2_r;
        q_r <= q_nxt;
    end

    assign q = q_r;
endmodule // dur_sync3

// ### hdl/dur_iso.sv
`timescale 1ns/10ps
module dur_iso (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // isolation control
    input wire logic iso,
    // raw inputs
    input wire dur_pkg::dur_req_t req_i,
    input wire logic [1:0] rx_i,
    // isolated inputs
    output dur_pkg::dur_req_t req_o,
    output logic [1:0] rx_o
);
    dur_pkg::dur_req_t held_r, held_nxt;
    logic [1:0] rx_r, rx_nxt;

    // ------------------------------------------------------------------
    // freeze address and data, kill strobes, park rx at idle
    // ------------------------------------------------------------------
    always_comb begin
        held_nxt = iso ? held_r : req_i;
        held_nxt.rd = 1'b0;
        held_nxt.wr = 1'b0;
        rx_nxt = iso ? 2'h3 : rx_i; // see R11
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            held_r <= '0;
            rx_r <= 2'h3;
        end else begin
            held_r <= held_nxt;
            rx_r <= rx_nxt;
        end
    end

    assign req_o = iso ? held_r : req_i; // see R11
    assign rx_o = rx_r;
endmodule // dur_iso

// ### hdl/dur_top.sv
`timescale 1ns/10ps
module dur_top (
    // clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pwr_on_rst,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // straps and serial inputs
    input wire logic bus_mode_68,
    input wire logic low_power_en,
    input wire logic [1:0] rx_i,
    input wire dur_pkg::dur_modem_t [1:0] modem_n,
    // channel outputs
    output dur_pkg::dur_pins_t [1:0] pins_o
);
    logic rst_any;
    logic [11:0] raw_in, syn_in;
    logic mode68_q, lowpwr_q, iso_act;
    logic [1:0] rx_q, rx_iso;
    dur_pkg::dur_modem_t [1:0] modem_q;
    dur_pkg::dur_req_t req_raw, req;
    logic ack_r, ack_nxt, req_any, take, wr_take, rd_take;
    logic [7:0] rdata_r, rdata_nxt;
    logic ch_sel;
    logic [3:0] idx;
    dur_pkg::dur_chan_t [1:0] ch_r, ch_nxt;
    dur_pkg::dur_div_t [1:0] div_r, div_nxt;
    logic [1:0][7:0] hold_r, hold_nxt;
    logic [1:0][3:0] stat, prev_r, prev_nxt;
    logic prev_ok_r, prev_ok_nxt;
    dur_pkg::dur_pins_t [1:0] pins_r, pins_nxt;

    assign rst_any = sys_rst | pwr_on_rst;

    // ------------------------------------------------------------------
    // pin synchronisers and sleep isolation
    // ------------------------------------------------------------------
    assign raw_in = {bus_mode_68, low_power_en, rx_i, modem_n};

    dur_sync3 #(.W(12)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(raw_in),
        .q(syn_in)
    );

    assign mode68_q = syn_in[11];
    assign lowpwr_q = syn_in[10];
    assign rx_q = syn_in[9:8];
    assign modem_q = syn_in[7:0];

    // sleep needs both channels asleep, no modem change, rx idle
    assign iso_act = lowpwr_q
        & ch_r[0].interrupt_enable_reg[dur_pkg::IER_SLEEP_BIT]
        & ch_r[1].interrupt_enable_reg[dur_pkg::IER_SLEEP_BIT]
        & ~|ch_r[0].msr_d & ~|ch_r[1].msr_d
        & (&rx_iso); // see R11

    assign req_raw = '{rd: avs_read, wr: avs_write,
        be0: avs_byteenable[0], addr: avs_address,
        wdata: avs_writedata[7:0]};

    dur_iso u_iso (
        .clk(clk),
        .sys_rst(sys_rst),
        .iso(iso_act),
        .req_i(req_raw),
        .rx_i(rx_q),
        .req_o(req),
        .rx_o(rx_iso)
    );

    // ------------------------------------------------------------------
    // bus slave: one wait state, answer in the next cycle
    // ------------------------------------------------------------------
    assign req_any = req.rd | req.wr;
    assign avs_waitrequest = req_any & ~ack_r;
    assign take = req_any & ack_r;
    assign wr_take = take & req.wr & req.be0
        & ~req.addr[dur_pkg::ADDR_HOLE_BIT];
    assign rd_take = take & req.rd & ~req.addr[dur_pkg::ADDR_HOLE_BIT];
    assign ch_sel = req.addr[dur_pkg::ADDR_CH_BIT];
    assign idx = req.addr[3:0];
    assign avs_readdata = {24'h000000, rdata_r};

    function automatic logic [7:0] guard(input logic [7:0] old_v,
            input logic [7:0] new_v, input logic [7:0] mask,
            input logic en);
        guard = en ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction

    function automatic logic [7:0] rd_val(input dur_pkg::dur_chan_t c,
            input dur_pkg::dur_div_t d, input logic [7:0] h,
            input logic [3:0] s, input logic [3:0] i);
        case (i)
            dur_pkg::REG_HOLD: rd_val = h;
            dur_pkg::REG_IER: rd_val = c.interrupt_enable_reg;
            dur_pkg::REG_FCR_ISR: rd_val = c.interrupt_status_reg;
            dur_pkg::REG_LCR: rd_val = c.line_control_reg;
            dur_pkg::REG_MCR: rd_val = c.modem_control_reg;
            dur_pkg::REG_LSR: rd_val = c.line_status_reg;
            dur_pkg::REG_MSR: rd_val = {s, c.msr_d}; // see R05
            dur_pkg::REG_SPR: rd_val = c.scratch_reg;
            dur_pkg::REG_DIV_LO: rd_val = d.lo;
            dur_pkg::REG_DIV_HI: rd_val = d.hi;
            dur_pkg::REG_FRAC: rd_val = c.fractional_divisor;
            dur_pkg::REG_EFR: rd_val = c.enhanced_feature_reg;
            dur_pkg::REG_RES1: rd_val = c.res1;
            dur_pkg::REG_RES2: rd_val = c.res2;
            dur_pkg::REG_PAU1: rd_val = c.pau1;
            dur_pkg::REG_PAU2: rd_val = c.pau2;
            default: rd_val = 8'h00;
        endcase
    endfunction

    always_comb begin
        ack_nxt = req_any & ~ack_r;
        rdata_nxt = rdata_r;
        if (ack_nxt) begin
            if (req.addr[dur_pkg::ADDR_HOLE_BIT]) begin
                rdata_nxt = 8'h00;
            end else begin
                rdata_nxt = rd_val(ch_r[ch_sel], div_r[ch_sel],
                    hold_r[ch_sel], stat[ch_sel], idx);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // modem status: live level and change flags
    // ------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            if (ch_r[c].modem_control_reg[dur_pkg::MCR_LOOP_BIT]) begin
                stat[c] = {ch_r[c].modem_control_reg[dur_pkg::MCR_OUT2_BIT],
                    ch_r[c].modem_control_reg[dur_pkg::MCR_OUT1_BIT],
                    ch_r[c].modem_control_reg[dur_pkg::MCR_DTR_BIT],
                    ch_r[c].modem_control_reg[dur_pkg::MCR_RTS_BIT]};
            end else begin
                stat[c] = ~modem_q[c]; // see R05
            end
        end
        prev_nxt = rst_any ? '0 : stat;
        prev_ok_nxt = ~rst_any;
    end

    always_ff @(posedge clk) begin
        prev_r <= prev_nxt;
        prev_ok_r <= prev_ok_nxt;
    end

    // ------------------------------------------------------------------
    // channel registers
    // ------------------------------------------------------------------
    always_comb begin
        ch_nxt = ch_r;
        div_nxt = div_r;
        for (int c = 0; c < 2; c++) begin
            // change flags: a set in the clearing cycle survives
            if (rd_take && ch_sel == c[0] && idx == dur_pkg::REG_MSR) begin
                ch_nxt[c].msr_d = 4'h0;
            end
            if (prev_ok_r) begin
                ch_nxt[c].msr_d = ch_nxt[c].msr_d | (stat[c] ^ prev_r[c]);
            end
            if (wr_take && ch_sel == c[0]) begin
                case (idx)
                    dur_pkg::REG_IER: ch_nxt[c].interrupt_enable_reg = guard(ch_r[c].interrupt_enable_reg,
                        req.wdata, dur_pkg::ENH_IER,
                        ch_r[c].enhanced_feature_reg[dur_pkg::EFR_ENH_BIT]);
                    dur_pkg::REG_FCR_ISR: ch_nxt[c].fifo_control_reg = guard(ch_r[c].fifo_control_reg,
                        req.wdata, dur_pkg::ENH_FCR,
                        ch_r[c].enhanced_feature_reg[dur_pkg::EFR_ENH_BIT]);
                    dur_pkg::REG_LCR: ch_nxt[c].line_control_reg = req.wdata;
                    dur_pkg::REG_MCR: ch_nxt[c].modem_control_reg = guard(ch_r[c].modem_control_reg,
                        req.wdata, dur_pkg::ENH_MCR,
                        ch_r[c].enhanced_feature_reg[dur_pkg::EFR_ENH_BIT]);
                    dur_pkg::REG_SPR: ch_nxt[c].scratch_reg = req.wdata;
                    dur_pkg::REG_DIV_LO: div_nxt[c].lo = req.wdata;
                    dur_pkg::REG_DIV_HI: div_nxt[c].hi = req.wdata;
                    dur_pkg::REG_FRAC: begin
                        if (ch_r[c].enhanced_feature_reg[dur_pkg::EFR_ENH_BIT]) begin
                            ch_nxt[c].fractional_divisor = req.wdata;
                        end
                    end
                    dur_pkg::REG_EFR: ch_nxt[c].enhanced_feature_reg = req.wdata;
                    dur_pkg::REG_RES1: ch_nxt[c].res1 = req.wdata; // see R02
                    dur_pkg::REG_RES2: ch_nxt[c].res2 = req.wdata; // see R02
                    dur_pkg::REG_PAU1: ch_nxt[c].pau1 = req.wdata; // see R02
                    dur_pkg::REG_PAU2: ch_nxt[c].pau2 = req.wdata; // see R02
                    default: ;
                endcase
            end
            if (rst_any) begin
                ch_nxt[c] = '{interrupt_enable_reg: dur_pkg::RST_ZERO,
                    fifo_control_reg: dur_pkg::RST_ZERO, interrupt_status_reg: dur_pkg::RST_ISR,
                    line_control_reg: dur_pkg::RST_ZERO, modem_control_reg: dur_pkg::RST_ZERO,
                    line_status_reg: dur_pkg::RST_LSR, scratch_reg: dur_pkg::RST_SPR,
                    enhanced_feature_reg: dur_pkg::RST_ZERO, fractional_divisor: dur_pkg::RST_ZERO,
                    res1: dur_pkg::RST_ZERO, res2: dur_pkg::RST_ZERO,
                    pau1: dur_pkg::RST_ZERO, pau2: dur_pkg::RST_ZERO,
                    msr_d: 4'h0}; // see R02 R03 R04 R05 R06 R07
            end
            // the reset pin leaves the divisor alone
            if (pwr_on_rst) begin
                div_nxt[c] = '{hi: dur_pkg::PWR_DIV_HI,
                    lo: dur_pkg::PWR_DIV_LO}; // see R01
            end
        end
    end

    always_ff @(posedge clk) begin
        ch_r <= ch_nxt;
        div_r <= div_nxt;
    end

    // holding data has no reset value
    always_comb begin
        hold_nxt = hold_r;
        if (wr_take && idx == dur_pkg::REG_HOLD) begin
            hold_nxt[ch_sel] = req.wdata; // see R08
        end
    end

    always_ff @(posedge clk) begin
        hold_r <= hold_nxt;
    end

    // ------------------------------------------------------------------
    // channel output pins
    // ------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            pins_nxt[c].tx = ~ch_r[c].line_control_reg[dur_pkg::LCR_BRK_BIT];
            pins_nxt[c].op2_n = ~ch_r[c].modem_control_reg[dur_pkg::MCR_OUT2_BIT];
            pins_nxt[c].rts_n = ~ch_r[c].modem_control_reg[dur_pkg::MCR_RTS_BIT];
            pins_nxt[c].dtr_n = ~ch_r[c].modem_control_reg[dur_pkg::MCR_DTR_BIT];
            pins_nxt[c].receive_ready_n_n = ~ch_r[c].line_status_reg[dur_pkg::LSR_RECEIVE_READY_N_BIT];
            pins_nxt[c].transmit_ready_n_n = ~ch_r[c].line_status_reg[dur_pkg::LSR_THRE_BIT];
            // nothing pending: mode 68 idles high, mode 16 idles low
            pins_nxt[c].irq = mode68_q;
            pins_nxt[c].irq_oe = mode68_q
                | ch_r[c].modem_control_reg[dur_pkg::MCR_OUT2_BIT];
            if (sys_rst) begin
                pins_nxt[c] = '{tx: 1'b1, op2_n: 1'b1, rts_n: 1'b1,
                    dtr_n: 1'b1, receive_ready_n_n: 1'b1, transmit_ready_n_n: 1'b0,
                    irq: mode68_q, irq_oe: mode68_q}; // see R09 R10
            end
        end
    end

    always_ff @(posedge clk) begin
        pins_r <= pins_nxt;
    end

    assign pins_o = pins_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_div_keep: assert property (@(posedge clk)
        sys_rst && !pwr_on_rst |=> $stable(div_r)) // see R01
        else $error("divisor changed on pin reset");
    a_div_power: assert property (@(posedge clk) pwr_on_rst |=>
        div_r[0].hi == 8'h00 && div_r[0].lo == 8'h01) // see R01
        else $error("divisor wrong after power-up");
    a_flow_clear: assert property (@(posedge clk) sys_rst |=>
        {ch_r[1].res1, ch_r[1].res2, ch_r[1].pau1, ch_r[1].pau2}
        == 32'h00000000) // see R02
        else $error("flow characters not cleared");
    a_isr_lsr: assert property (@(posedge clk) sys_rst |=>
        ch_r[0].interrupt_status_reg == 8'h01 && ch_r[0].line_status_reg == 8'h60) // see R03 R04
        else $error("status reset value wrong");
    a_msr_reset: assert property (@(posedge clk) sys_rst ##1 sys_rst
        |-> ch_r[0].msr_d == 4'h0 && ch_r[1].msr_d == 4'h0) // see R05
        else $error("modem change flags not cleared");
    a_msr_level: assert property (@(posedge clk) disable iff (rst_any)
        !ch_r[0].modem_control_reg[dur_pkg::MCR_LOOP_BIT]
        |-> stat[0] == ~modem_q[0]) // see R05
        else $error("modem level not inverted pin");
    a_spr_ctrl: assert property (@(posedge clk) sys_rst |=>
        ch_r[0].scratch_reg == 8'hff && ch_r[0].interrupt_enable_reg == 8'h00
        && ch_r[0].modem_control_reg == 8'h00 && ch_r[0].enhanced_feature_reg == 8'h00
        && ch_r[0].fractional_divisor == 8'h00 && ch_r[0].line_control_reg == 8'h00) // see R06 R07
        else $error("control reset value wrong");
    a_pin_reset: assert property (@(posedge clk) sys_rst |=>
        pins_o[0].tx && pins_o[0].rts_n && pins_o[0].dtr_n
        && pins_o[0].op2_n && pins_o[0].receive_ready_n_n
        && !pins_o[0].transmit_ready_n_n) // see R09
        else $error("pin level wrong in reset");
    a_irq_mode: assert property (@(posedge clk) sys_rst [*6]
        |-> pins_o[1].irq_oe == $past(mode68_q)
        && (pins_o[1].irq || !pins_o[1].irq_oe)) // see R10
        else $error("interrupt pin wrong in reset");
    a_iso_block: assert property (@(posedge clk) disable iff (rst_any)
        iso_act |=> $stable(ch_r[0].scratch_reg) && rx_iso == 2'h3) // see R11
        else $error("isolated input reached logic");
    a_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
        req_any && !ack_r |=> !avs_waitrequest || !req_any)
        else $error("bus answer late");

    c_write: cover property (@(posedge clk) wr_take);
    c_msr_read: cover property (@(posedge clk)
        rd_take && idx == dur_pkg::REG_MSR && |ch_r[0].msr_d);
    c_iso: cover property (@(posedge clk) iso_act);
    c_power: cover property (@(posedge clk) pwr_on_rst ##1 sys_rst);
endmodule // dur_top

// ### verif/dur_host.sv
`timescale 1ns/10ps
module dur_host (
    // clock
    input wire logic clk,
    // avalon-mm master side
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [3:0] avs_byteenable,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // ------------------------------------------------------------------
    // host processor model
    // ------------------------------------------------------------------
    initial begin
        avs_address = 6'h3f;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'hffff_ffff;
    end

    // entered just after a rising edge; a released bus shows the inverse
    task automatic xfer(input logic wr, input logic [5:0] a,
            input logic [7:0] d, input logic be0, output logic [7:0] q);
        q = 8'hxx;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_byteenable <= {3'h0, be0};
        avs_writedata <= {24'h0, d};
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~{24'h0, d};
        @(posedge clk);
    endtask
endmodule // dur_host

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk, sys_rst, pwr_on_rst, bus_mode_68, low_power_en;
    logic [5:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0] rx_i;
    dur_pkg::dur_modem_t [1:0] modem_n;
    dur_pkg::dur_pins_t [1:0] pins_o;
    int failures = 0;
    int n_checks = 0;

    dur_host host (.clk(clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    dur_top DUT (.clk(clk), .sys_rst(sys_rst), .pwr_on_rst(pwr_on_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_mode_68(bus_mode_68),
        .low_power_en(low_power_en), .rx_i(rx_i), .modem_n(modem_n),
        .pins_o(pins_o));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
            input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic ch, input logic [3:0] i,
            input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b1, {1'b0, ch, i}, d, 1'b1, q);
    endtask
    task automatic rd_chk(input logic ch, input logic [3:0] i,
            input logic [7:0] exp, input string what);
        logic [7:0] q;
        host.xfer(1'b0, {1'b0, ch, i}, 8'h00, 1'b1, q);
        check(q, exp, what);
    endtask
    task automatic rst(input logic pwr);
        sys_rst <= 1'b1;
        pwr_on_rst <= pwr;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        pwr_on_rst <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic chk_regs(input logic ch);
        logic [7:0] e [16] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60,
            8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00};
        for (int i = 1; i < 16; i++) begin
            if (i != 6 && i != 8 && i != 9)
                rd_chk(ch, 4'(i), e[i], "reset");
        end
    endtask
    task automatic t_char_regs(input logic ch);
        logic [7:0] q;
        wr(ch, 4'hb, 8'h10);
        wr(ch, 4'ha, 8'h05);
        for (int i = 1; i < 5; i++) wr(ch, 4'(i), 8'h03);
        for (int i = 12; i < 16; i++) wr(ch, 4'(i), 8'(8'ha0 + i + ch));
        wr(ch, 4'h7, 8'h3c);
        wr(ch, 4'h5, 8'h00);
        host.xfer(1'b1, {1'b0, ch, 4'h7}, 8'hc3, 1'b0, q);
        for (int i = 12; i < 16; i++)
            rd_chk(ch, 4'(i), 8'(8'ha0 + i + ch), "flow char");
        rd_chk(ch, 4'h7, 8'h3c, "scratch");
        rd_chk(ch, 4'h5, 8'h60, "line status read-only");
        rd_chk(ch, 4'ha, 8'h05, "fraction");
        host.xfer(1'b0, {2'b10, ch, 3'h0}, 8'h00, 1'b1, q);
        check(q, 8'h00, "unmapped read");
        rst(1'b0);
        chk_regs(ch);
    endtask
    task automatic t_msr();
        logic [7:0] q;
        modem_n[0].cts_n <= 1'b1;
        repeat (8) @(posedge clk);
        modem_n <= 8'h50;
        repeat (8) @(posedge clk);
        rst(1'b0);
        rd_chk(1'b0, 4'h6, 8'hf0, "modem status after reset");
        host.xfer(1'b0, 6'h16, 8'h00, 1'b1, q);
        rd_chk(1'b1, 4'h6, 8'ha0, "modem status levels");
    endtask
    task automatic t_pins(input logic m68);
        logic [7:0] e;
        bus_mode_68 <= m68;
        for (int c = 0; c < 2; c++) begin
            wr(1'(c), 4'h3, 8'h40);
            wr(1'(c), 4'h4, 8'h0b);
        end
        wr(1'b0, 4'h8, 8'h34);
        wr(1'b0, 4'h9, 8'h12);
        repeat (2) @(posedge clk);
        check(pins_o[0], {6'b000010, m68, 1'b1}, "pins running");
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        e = {6'b111110, m68, m68};
        check(pins_o[0], e, "pins in reset ch0");
        check(pins_o[1], e, "pins in reset ch1");
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        rd_chk(1'b0, 4'h8, 8'h34, "divisor low kept");
        rd_chk(1'b0, 4'h9, 8'h12, "divisor high kept");
    endtask
    task automatic t_sleep();
        logic [7:0] q;
        for (int c = 0; c < 2; c++) begin
            wr(1'(c), 4'hb, 8'h10);
            wr(1'(c), 4'h1, 8'h10);
            wr(1'(c), 4'h7, 8'h11);
            host.xfer(1'b0, {1'b0, 1'(c), 4'h6}, 8'h00, 1'b1, q);
        end
        low_power_en <= 1'b1;
        repeat (8) @(posedge clk);
        wr(1'b0, 4'h7, 8'h5a);
        modem_n[1].ri_n <= 1'b0;
        repeat (8) @(posedge clk);
        rd_chk(1'b0, 4'h7, 8'h11, "write dropped in sleep");
        rd_chk(1'b1, 4'h6, 8'he4, "modem live in sleep");
        low_power_en <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        sys_rst = 1'b1;
        pwr_on_rst = 1'b1;
        bus_mode_68 = 1'b0;
        low_power_en = 1'b0;
        rx_i = 2'b11;
        modem_n = 8'h00;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        pwr_on_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk_regs(1'b0);
        chk_regs(1'b1);
        rd_chk(1'b1, 4'h8, 8'h01, "divisor low power-up");
        rd_chk(1'b1, 4'h9, 8'h00, "divisor high power-up");
        t_char_regs(1'b0);
        t_char_regs(1'b1);
        t_msr();
        t_pins(1'b0);
        t_pins(1'b1);
        t_sleep();
        rst(1'b1);
        rd_chk(1'b0, 4'h8, 8'h01, "divisor low power-up");
        rd_chk(1'b0, 4'h9, 8'h00, "divisor high power-up");
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("FAIL %0t watchdog expired", $time);
        conclude();
    end
endmodule // testbench
